//--- mfs_defines.vh
// constants for the motor fault and status register block
`ifndef MFS_DEFINES_VH
`define MFS_DEFINES_VH

// ****************************************************************
// register map
// ****************************************************************
`define MFS_ADDR_W            3
`define MFS_DATA_W            12
`define MFS_FAULT_STATUS_ADDR 3'h7
`define MFS_FAULT_STATUS_RST  12'h000

// ****************************************************************
// fault_status field positions
// ****************************************************************
`define MFS_BIT_OTS      0
`define MFS_BIT_OCP_A    1
`define MFS_BIT_OCP_B    2
`define MFS_BIT_PDF_A    3
`define MFS_BIT_PDF_B    4
`define MFS_BIT_UNDERVOLTAGE_LOCKOUT_FLAG     5
`define MFS_BIT_STALL    6
`define MFS_BIT_STALLLAT 7
`define MFS_NUM_FLAGS    8

// ****************************************************************
// serial frame layout
// ****************************************************************
`define MFS_FRAME_LEN    5'h10
`define MFS_HDR_LEN      5'h04
`define MFS_FRM_RW_BIT   15
`define MFS_FRM_ADDR_HI  14
`define MFS_FRM_ADDR_LO  12
`define MFS_CNT_W        5

// ****************************************************************
// recommended dead time with a series low-side gate resistor
// ****************************************************************
`define MFS_DEAD_TIME_REC_NS 850

`endif

//--- mfs_fault_status.v
// motor fault and status register with drive hold control
//
// Function
// (RULE_01) Bit 0 goes to one on entering overtemperature shutdown and is zero in normal running.
// (RULE_02) A zero write clears the overtemperature bit, and drive restarts alone once it is cool.
// (RULE_03) Bit 1 sets on a channel A overcurrent stop, and a zero write clears it and resumes.
// (RULE_04) Bit 2 sets on a channel B overcurrent stop, and a zero write clears it and resumes.
// (RULE_05) Bit 3 sets on a channel A predriver fault, and a zero write clears it and restarts.
// (RULE_06) Bit 4 sets on a channel B predriver fault, and a zero write clears it and restarts.
// (RULE_07) Bit 5 sets on undervoltage lockout, clears by zero write, and drive resumes on supply.
// (RULE_08) A zero write to the undervoltage bit is ignored while the device sleeps.
// (RULE_09) Bit 6 is a read-only live stall indication that reads zero in normal running.
// (RULE_10) Bit 7 latches a stall until a zero write, which clears it and resumes drive.
// (RULE_11) Software should set a dead time of 850 ns when a series low-side gate resistor is fitted.
// (RULE_12) Bits 11 to 8 read as zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "mfs_defines.vh"

module mfs_fault_status (
  // clock and reset
  input  wire                   clk_sys,
  input  wire                   rstn,
  // serial control port
  input  wire                   scs_n,
  input  wire                   sclk,
  input  wire                   mosi,
  output wire                   miso_o,
  output wire                   miso_oe,
  // fault conditions from protection logic, and the sleep mode input
  input  wire                   overtemp_cond,
  input  wire                   ocp_a_trip,
  input  wire                   ocp_b_trip,
  input  wire                   pdf_a_trip,
  input  wire                   pdf_b_trip,
  input  wire                   undervoltage_cond,
  input  wire                   stall_cond,
  input  wire                   sleep_mode,
  // status and drive control
  output wire [`MFS_DATA_W-1:0] fault_status_o,
  output reg                    drive_en_a_q,
  output reg                    drive_en_b_q,
  output reg  [2:0]             op_state_q
);

  // ****************************************************************
  // operating states
  // ****************************************************************
  localparam [2:0] ST_RUN        = 3'b001;
  localparam [2:0] ST_AUTO_HOLD  = 3'b010;
  localparam [2:0] ST_LATCH_HOLD = 3'b100;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // zero-write clear request for one bit of the status register
  function clr_req;
    input                   hit;
    input [`MFS_DATA_W-1:0] data;
    input integer           pos;
    begin
      clr_req = hit && !data[pos];
    end
  endfunction

  // address decode shared by the write strobe and the read mux
  function addr_is_status;
    input [`MFS_ADDR_W-1:0] addr;
    begin
      addr_is_status = (addr == `MFS_FAULT_STATUS_ADDR);
    end
  endfunction

  // a bridge runs only in the run state with no stop flag and no live trip
  function chan_run;
    input [2:0] state;
    input       stop;
    input       ocp_trip;
    input       pdf_trip;
    begin
      chan_run = (state == ST_RUN) && !stop && !ocp_trip && !pdf_trip;
    end
  endfunction

  // ****************************************************************
  // serial port
  // ****************************************************************
  wire [`MFS_ADDR_W-1:0] reg_addr;
  wire                   wr_strobe;
  wire [`MFS_DATA_W-1:0] wr_data;
  reg  [`MFS_DATA_W-1:0] rd_data;

  mfs_spi_slave u_spi (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .scs_n       (scs_n),
    .sclk        (sclk),
    .mosi        (mosi),
    .miso_q      (miso_o),
    .miso_oe_q   (miso_oe),
    .rd_data     (rd_data),
    .reg_addr_q  (reg_addr),
    .wr_strobe_q (wr_strobe),
    .wr_data_q   (wr_data)
  );

  wire wr_hit = wr_strobe && addr_is_status(reg_addr);

  // ****************************************************************
  // write decode
  // ****************************************************************
  // only the seven writable flags get a clear wire; a write to the live
  // stall bit or the upper nibble decodes to nothing
  wire clr_ots   = clr_req(wr_hit, wr_data, `MFS_BIT_OTS);           // [RULE_02]
  wire clr_ocp_a = clr_req(wr_hit, wr_data, `MFS_BIT_OCP_A);         // [RULE_03]
  wire clr_ocp_b = clr_req(wr_hit, wr_data, `MFS_BIT_OCP_B);         // [RULE_04]
  wire clr_pdf_a = clr_req(wr_hit, wr_data, `MFS_BIT_PDF_A);         // [RULE_05]
  wire clr_pdf_b = clr_req(wr_hit, wr_data, `MFS_BIT_PDF_B);         // [RULE_06]
  wire clr_undervoltage_lockout_flag  = clr_req(wr_hit, wr_data, `MFS_BIT_UNDERVOLTAGE_LOCKOUT_FLAG);          // [RULE_07]
  wire clr_stall = clr_req(wr_hit, wr_data, `MFS_BIT_STALLLAT);      // [RULE_10] [RULE_12]

  // ****************************************************************
  // sticky flags
  // ****************************************************************
  wire overtemp_shutdown_flag;
  wire chan_a_overcurrent_flag;
  wire chan_b_overcurrent_flag;
  wire chan_a_predriver_fault_flag;
  wire chan_b_predriver_fault_flag;
  wire undervoltage_lockout_flag;
  wire stall_latched_flag;
  reg  stall_live_flag;

  // events set while the condition stands, so a clear during it has no effect
  mfs_flag_cell u_ots (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .set_i       (overtemp_cond),                                    // [RULE_01]
    .clr_i       (clr_ots),                                          // [RULE_02]
    .clr_block_i (1'b0),
    .flag_q      (overtemp_shutdown_flag)
  );

  mfs_flag_cell u_ocp_a (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .set_i       (ocp_a_trip),                                       // [RULE_03]
    .clr_i       (clr_ocp_a),                                        // [RULE_03]
    .clr_block_i (1'b0),
    .flag_q      (chan_a_overcurrent_flag)
  );

  mfs_flag_cell u_ocp_b (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .set_i       (ocp_b_trip),                                       // [RULE_04]
    .clr_i       (clr_ocp_b),                                        // [RULE_04]
    .clr_block_i (1'b0),
    .flag_q      (chan_b_overcurrent_flag)
  );

  mfs_flag_cell u_pdf_a (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .set_i       (pdf_a_trip),                                       // [RULE_05]
    .clr_i       (clr_pdf_a),                                        // [RULE_05]
    .clr_block_i (1'b0),
    .flag_q      (chan_a_predriver_fault_flag)
  );

  mfs_flag_cell u_pdf_b (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .set_i       (pdf_b_trip),                                       // [RULE_06]
    .clr_i       (clr_pdf_b),                                        // [RULE_06]
    .clr_block_i (1'b0),
    .flag_q      (chan_b_predriver_fault_flag)
  );

  mfs_flag_cell u_undervoltage_lockout_flag (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .set_i       (undervoltage_cond),                                // [RULE_07]
    .clr_i       (clr_undervoltage_lockout_flag),                                         // [RULE_07]
    .clr_block_i (sleep_mode),                                       // [RULE_08]
    .flag_q      (undervoltage_lockout_flag)
  );

  mfs_flag_cell u_stall_lat (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .set_i       (stall_cond),                                       // [RULE_10]
    .clr_i       (clr_stall),                                        // [RULE_10]
    .clr_block_i (1'b0),
    .flag_q      (stall_latched_flag)
  );

  // live stall bit follows the detector and takes no write
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stall_live_flag <= 1'b0;
    end else begin
      stall_live_flag <= stall_cond;                                 // [RULE_09]
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  wire [`MFS_NUM_FLAGS-1:0] flags;

  assign flags = {stall_latched_flag,
                  stall_live_flag,
                  undervoltage_lockout_flag,
                  chan_b_predriver_fault_flag,
                  chan_a_predriver_fault_flag,
                  chan_b_overcurrent_flag,
                  chan_a_overcurrent_flag,
                  overtemp_shutdown_flag};

  // upper nibble tied to zero; writes there land nowhere
  wire [`MFS_DATA_W-`MFS_NUM_FLAGS-1:0] rsvd_bits;

  assign rsvd_bits      = 4'h0;                                      // [RULE_12]
  assign fault_status_o = {rsvd_bits, flags};                        // [RULE_12]

  // unmapped addresses read zero
  always @* begin
    if (addr_is_status(reg_addr)) begin
      rd_data = fault_status_o;
    end else begin
      rd_data = 12'h000;
    end
  end

  // ****************************************************************
  // drive hold control
  // ****************************************************************
  // temperature and supply holds follow the live condition, not the flag,
  // so drive comes back without software once they recover
  wire auto_hold  = overtemp_cond || undervoltage_cond;              // [RULE_02] [RULE_07]
  wire latch_hold = stall_latched_flag;                              // [RULE_10]
  reg  [2:0] op_state_d;

  always @* begin
    case (op_state_q)
      ST_RUN: begin
        if (auto_hold) begin
          op_state_d = ST_AUTO_HOLD;
        end else if (latch_hold) begin
          op_state_d = ST_LATCH_HOLD;
        end else begin
          op_state_d = ST_RUN;
        end
      end
      ST_AUTO_HOLD: begin
        if (auto_hold) begin
          op_state_d = ST_AUTO_HOLD;
        end else if (latch_hold) begin
          op_state_d = ST_LATCH_HOLD;
        end else begin
          op_state_d = ST_RUN;
        end
      end
      ST_LATCH_HOLD: begin
        if (auto_hold) begin
          op_state_d = ST_AUTO_HOLD;
        end else if (latch_hold) begin
          op_state_d = ST_LATCH_HOLD;
        end else begin
          op_state_d = ST_RUN;
        end
      end
      default: begin
        op_state_d = ST_RUN;
      end
    endcase
  end

  // ****************************************************************
  // drive enables
  // ****************************************************************
  // per-channel faults stop only their own bridge until cleared
  wire chan_a_stop = chan_a_overcurrent_flag || chan_a_predriver_fault_flag; // [RULE_03] [RULE_05]
  wire chan_b_stop = chan_b_overcurrent_flag || chan_b_predriver_fault_flag; // [RULE_04] [RULE_06]
  // a live trip stops the bridge at once instead of waiting a cycle for its flag
  wire chan_a_run  = chan_run(op_state_d, chan_a_stop, ocp_a_trip, pdf_a_trip);
  wire chan_b_run  = chan_run(op_state_d, chan_b_stop, ocp_b_trip, pdf_b_trip);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_state_q   <= ST_RUN;
      drive_en_a_q <= 1'b0;
      drive_en_b_q <= 1'b0;
    end else begin
      op_state_q   <= op_state_d;
      drive_en_a_q <= chan_a_run;                                    // [RULE_03] [RULE_05]
      drive_en_b_q <= chan_b_run;                                    // [RULE_04] [RULE_06]
    end
  end

endmodule // mfs_fault_status

`default_nettype wire

//--- mfs_fault_status_chk.sv
// assertion checker for the motor fault and status register
`timescale 1ns/10ps
`default_nettype none
`include "mfs_defines.vh"

module mfs_fault_status_chk (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  // serial port and conditions
  input wire logic                   scs_n,
  input wire logic                   overtemp_cond,
  input wire logic                   ocp_a_trip,
  input wire logic                   ocp_b_trip,
  input wire logic                   pdf_a_trip,
  input wire logic                   pdf_b_trip,
  input wire logic                   undervoltage_cond,
  input wire logic                   stall_cond,
  input wire logic                   sleep_mode,
  // status and drive
  input wire logic [`MFS_DATA_W-1:0] fault_status_o,
  input wire logic                   drive_en_a_q
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic [2:0] end_cnt_q;
  logic       slp1_q;
  logic       slp2_q;
  wire        quiet_a;
  // a clear may only land a few cycles after a frame ends
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      end_cnt_q <= 3'h7;
      slp1_q    <= 1'b0;
      slp2_q    <= 1'b0;
    end else begin
      end_cnt_q <= !scs_n ? 3'h0 : (end_cnt_q == 3'h7 ? 3'h7 : end_cnt_q + 3'h1);
      slp1_q    <= sleep_mode;
      slp2_q    <= slp1_q;
    end
  end
  assign quiet_a = !(overtemp_cond | undervoltage_cond | stall_cond | ocp_a_trip | pdf_a_trip
                   | sleep_mode | fault_status_o[1] | fault_status_o[3] | fault_status_o[7]);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_quiet_a;
    quiet_a [*2];
  endsequence
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_ots_set: assert property (overtemp_cond |=> fault_status_o[0])
    else $error("overtemp flag not set");
  a_ocpa_stop: assert property (ocp_a_trip |=> fault_status_o[1] ##1 !drive_en_a_q)
    else $error("chan a overcurrent not handled");
  a_ocpb_set: assert property (ocp_b_trip |=> fault_status_o[2])
    else $error("chan b overcurrent flag not set");
  a_pdfa_set: assert property (pdf_a_trip |=> fault_status_o[3])
    else $error("chan a predriver flag not set");
  a_pdfb_set: assert property (pdf_b_trip |=> fault_status_o[4])
    else $error("chan b predriver flag not set");
  a_uv_set: assert property (undervoltage_cond |=> fault_status_o[5])
    else $error("undervoltage flag not set");
  a_stall_live: assert property (fault_status_o[6] == $past(stall_cond))
    else $error("live stall bit wrong");
  a_stall_latch: assert property (stall_cond |=> fault_status_o[7])
    else $error("stall latch not set");
  a_rsvd_zero: assert property (fault_status_o[11:8] == 4'h0)
    else $error("reserved bits not zero");
  a_clr_by_frame: assert property (|($past(fault_status_o[7:0]) & ~fault_status_o[7:0] & 8'hbf) |-> end_cnt_q inside {[1:4]})
    else $error("flag cleared without a write");
  a_uv_sleep_hold: assert property (slp2_q && slp1_q && sleep_mode && $past(fault_status_o[5]) |-> fault_status_o[5])
    else $error("undervoltage flag cleared in sleep");
  a_a_resume: assert property (s_quiet_a |=> drive_en_a_q)
    else $error("chan a drive not resumed");
endmodule // mfs_fault_status_chk
`default_nettype wire

//--- mfs_fault_status_tb_top.sv
// self-checking testbench for the motor fault and status register
`timescale 1ns/10ps
`default_nettype none
`include "mfs_defines.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module mfs_fault_status_tb_top;
  logic                   clk_sys = 1'b0;
  logic                   rstn    = 1'b0;
  logic                   scs_n   = 1'b1;
  logic                   sclk    = 1'b0;
  logic                   mosi    = 1'b0;
  logic                   sleep_mode = 1'b0;
  logic [6:0]             cond_v  = 7'h00;
  logic [11:0]            rd_v;
  logic [11:0]            exp_f;
  wire                    miso_o;
  wire                    miso_oe;
  wire  [`MFS_DATA_W-1:0] fault_status_o;
  wire                    drive_en_a_q;
  wire                    drive_en_b_q;
  wire  [2:0]             op_state_q;
  int                     error_cnt = 0;
  int                     n_checks  = 0;
  int                     cyc       = 0;

  always #10 clk_sys = ~clk_sys;

  mfs_fault_status dut (
    .clk_sys(clk_sys), .rstn(rstn), .scs_n(scs_n), .sclk(sclk), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .overtemp_cond(cond_v[0]), .ocp_a_trip(cond_v[1]),
    .ocp_b_trip(cond_v[2]), .pdf_a_trip(cond_v[3]), .pdf_b_trip(cond_v[4]),
    .undervoltage_cond(cond_v[5]), .stall_cond(cond_v[6]), .sleep_mode(sleep_mode),
    .fault_status_o(fault_status_o), .drive_en_a_q(drive_en_a_q),
    .drive_en_b_q(drive_en_b_q), .op_state_q(op_state_q));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // sclk high for 4 clocks and low for 9 keeps above the sampling minimum
  task automatic frame(input logic [15:0] w);
    rd_v = 12'h000;
    @(posedge clk_sys) scs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk_sys) mosi <= w[i];
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sclk <= 1'b0;
      repeat (4) @(posedge clk_sys);
      if (i >= 1 && i <= 12) rd_v[i-1] = miso_o;
      if (i == 1) `CHK("miso_oe", w[15], miso_oe)
    end
    @(posedge clk_sys) scs_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK("miso_oe_idle", 1'b0, miso_oe)
  endtask

  task automatic wr(input logic [2:0] a, input logic [11:0] d);
    frame({1'b0, a, d});
  endtask

  task automatic rd(input logic [2:0] a, input logic [11:0] ex, input string nm);
    frame({1'b1, a, 12'h000});
    `CHK(nm, ex, rd_v)
  endtask

  task automatic pulse(input int b);
    @(posedge clk_sys) cond_v <= 7'h01 << b;
    @(posedge clk_sys) cond_v <= 7'h00;
    repeat (3) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      conclude();
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("op_state", 3'h1, op_state_q)
    rd(3'h7, 12'h000, "status_rst");
    `CHK("dead_time_rec", 850, `MFS_DEAD_TIME_REC_NS)
    for (int b = 0; b < 7; b++) begin
      pulse(b);
      exp_f = (b == 6) ? 12'h080 : (12'h001 << b);
      rd(3'h7, exp_f, "flag_set");
      `CHK("drive_a", !(b == 1 || b == 3 || b == 6), drive_en_a_q)
      `CHK("drive_b", !(b == 2 || b == 4 || b == 6), drive_en_b_q)
      wr(3'h7, 12'hfff);
      rd(3'h7, exp_f, "flag_one_wr");
      wr(3'h7, ~exp_f);
      rd(3'h7, 12'h000, "flag_clr");
      `CHK("drive_back", 2'h3, {drive_en_a_q, drive_en_b_q})
    end
    // a zero write loses while the stall is still present
    @(posedge clk_sys) cond_v <= 7'h40;
    repeat (3) @(posedge clk_sys);
    `CHK("op_hold", 3'h4, op_state_q)
    wr(3'h7, 12'h000);
    rd(3'h7, 12'h0c0, "stall_live");
    @(posedge clk_sys) cond_v <= 7'h00;
    rd(3'h7, 12'h080, "stall_gone");
    wr(3'h7, 12'h000);
    @(posedge clk_sys) cond_v <= 7'h01;
    repeat (3) @(posedge clk_sys);
    `CHK("ots_drive", 2'h0, {drive_en_a_q, drive_en_b_q})
    `CHK("ots_state", 3'h2, op_state_q)
    @(posedge clk_sys) cond_v <= 7'h00;
    repeat (3) @(posedge clk_sys);
    `CHK("ots_resume", 2'h3, {drive_en_a_q, drive_en_b_q})
    rd(3'h7, 12'h001, "ots_kept");
    pulse(5);
    @(posedge clk_sys) sleep_mode <= 1'b1;
    wr(3'h7, 12'h000);
    rd(3'h7, 12'h020, "uv_sleep");
    @(posedge clk_sys) sleep_mode <= 1'b0;
    wr(3'h7, 12'h000);
    rd(3'h7, 12'h000, "uv_clr");
    pulse(1);
    wr(3'h3, 12'h000);
    rd(3'h3, 12'h000, "unmapped_rd");
    `CHK("unmapped_wr", 12'h002, fault_status_o)
    conclude();
  end
endmodule // mfs_fault_status_tb_top

bind mfs_fault_status mfs_fault_status_chk u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .scs_n(scs_n), .overtemp_cond(overtemp_cond),
  .ocp_a_trip(ocp_a_trip), .ocp_b_trip(ocp_b_trip), .pdf_a_trip(pdf_a_trip),
  .pdf_b_trip(pdf_b_trip), .undervoltage_cond(undervoltage_cond), .stall_cond(stall_cond),
  .sleep_mode(sleep_mode), .fault_status_o(fault_status_o), .drive_en_a_q(drive_en_a_q));
`default_nettype wire

//--- mfs_flag_cell.v
// one sticky fault flag with write-zero clear
`timescale 1ns/10ps
`default_nettype none

module mfs_flag_cell (
  // clock and reset
  input  wire clk_sys,
  input  wire rstn,
  // control
  input  wire set_i,
  input  wire clr_i,
  input  wire clr_block_i,
  // state
  output reg  flag_q
);

  wire flag_d;

  // set beats a clear arriving in the same cycle so no event is lost
  assign flag_d = set_i ? 1'b1 : ((clr_i && !clr_block_i) ? 1'b0 : flag_q);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule // mfs_flag_cell

`default_nettype wire

//--- mfs_spi_slave.v
// serial control port slave: 16-bit frames, mode 0, msb first
`timescale 1ns/10ps
`default_nettype none
`include "mfs_defines.vh"

module mfs_spi_slave (
  // clock and reset
  input  wire                     clk_sys,
  input  wire                     rstn,
  // serial pins
  input  wire                     scs_n,
  input  wire                     sclk,
  input  wire                     mosi,
  output reg                      miso_q,
  output reg                      miso_oe_q,
  // register side
  input  wire [`MFS_DATA_W-1:0]   rd_data,
  output reg  [`MFS_ADDR_W-1:0]   reg_addr_q,
  output reg                      wr_strobe_q,
  output reg  [`MFS_DATA_W-1:0]   wr_data_q
);

  reg                     sclk_q;
  reg                     scs_n_q;
  reg  [`MFS_CNT_W-1:0]   bit_cnt_q;
  reg  [15:0]             shift_in_q;
  reg  [`MFS_DATA_W-1:0]  shift_out_q;
  reg                     rw_q;
  reg                     load_q;

  wire active   = !scs_n;
  wire sclk_re  = active && sclk && !sclk_q;
  wire sclk_fe  = active && !sclk && sclk_q;
  wire frame_end = scs_n && !scs_n_q;
  wire full_frame = (bit_cnt_q == `MFS_FRAME_LEN);

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclk_q      <= 1'b0;
      scs_n_q     <= 1'b1;
      bit_cnt_q   <= {`MFS_CNT_W{1'b0}};
      shift_in_q  <= 16'h0000;
      shift_out_q <= `MFS_FAULT_STATUS_RST;
      rw_q        <= 1'b0;
      load_q      <= 1'b0;
      reg_addr_q  <= {`MFS_ADDR_W{1'b0}};
      wr_strobe_q <= 1'b0;
      wr_data_q   <= `MFS_FAULT_STATUS_RST;
      miso_q      <= 1'b0;
      miso_oe_q   <= 1'b0;
    end else begin
      sclk_q      <= sclk;
      scs_n_q     <= scs_n;
      wr_strobe_q <= 1'b0;
      load_q      <= 1'b0;
      if (!active) begin
        bit_cnt_q <= {`MFS_CNT_W{1'b0}};
        miso_oe_q <= 1'b0;
        miso_q    <= 1'b0;
        // a write commits only on a whole frame, so a cut frame changes nothing
        if (frame_end && full_frame && !shift_in_q[`MFS_FRM_RW_BIT]) begin
          wr_strobe_q <= 1'b1;
          wr_data_q   <= shift_in_q[`MFS_DATA_W-1:0];
          reg_addr_q  <= shift_in_q[`MFS_FRM_ADDR_HI:`MFS_FRM_ADDR_LO];
        end
      end else begin
        if (sclk_re && !full_frame) begin
          shift_in_q <= {shift_in_q[14:0], mosi};
          bit_cnt_q  <= bit_cnt_q + 5'h01;
          if (bit_cnt_q == `MFS_HDR_LEN - 5'h01) begin
            rw_q       <= shift_in_q[2];
            reg_addr_q <= {shift_in_q[1:0], mosi};
            load_q     <= 1'b1;
          end
        end
        // read data is a snapshot taken right after the address bits
        if (load_q) begin
          shift_out_q <= rd_data;
          miso_oe_q   <= rw_q;
        end
        if (sclk_fe && (bit_cnt_q >= `MFS_HDR_LEN) && !full_frame) begin
          miso_q      <= shift_out_q[`MFS_DATA_W-1];
          shift_out_q <= {shift_out_q[`MFS_DATA_W-2:0], 1'b0};
        end
      end
    end
  end

endmodule // mfs_spi_slave

`default_nettype wire
